/* File: dtc_pkg.sv */
// Constants shared by the termination-control device end and its controller end.
// Assumes both ends run on one system clock and meet over the dtc_link_if pins.
package dtc_pkg;
  // ********************************
  // Link clock and latencies
  // ********************************
  localparam int CK_DIV = 8;            // System cycles per link clock period
  localparam int CK_HALF = 4;           // System cycles of link clock high time
  localparam logic [5:0] CWL_BASE = 6'h05;
  localparam logic [5:0] CL_BASE = 6'h04;
  localparam logic [5:0] ODTL_SUB = 6'h02;
  localparam logic [5:0] TAIL_BC4 = 6'h04;
  localparam logic [5:0] TAIL_BL8 = 6'h06;
  localparam logic [3:0] HOLD_BASE = 4'h4;   // Least high time of the pin
  localparam logic [3:0] HOLD_BL8 = 4'h6;
  // ********************************
  // Mode register fields
  // ********************************
  localparam int MR_W = 16;
  localparam logic [MR_W-1:0] MR_RST = 16'h0000;
  localparam int MR1_DLL_OFF = 0;
  localparam int MR1_NOM_B0 = 2;
  localparam int MR1_NOM_B1 = 6;
  localparam int MR1_NOM_B2 = 9;
  localparam int MR1_AL_LO = 3;
  localparam int MR2_CWL_LO = 3;
  localparam int MR2_WR_LO = 9;
  localparam int MR0_CL_LO = 4;
  localparam logic [1:0] SEL_MR0 = 2'h0;
  localparam logic [1:0] SEL_MR1 = 2'h1;
  localparam logic [1:0] SEL_MR2 = 2'h2;
  // Termination strength codes, shared by nominal field and output
  localparam logic [2:0] RTT_OFF = 3'h0;
  localparam logic [2:0] RTT_DIV4 = 3'h1;
  localparam logic [2:0] RTT_DIV2 = 3'h2;
  localparam logic [2:0] RTT_DIV12 = 3'h4;
  localparam logic [2:0] RTT_DIV8 = 3'h5;
  localparam logic [1:0] WR_DIV4 = 2'h1;
  localparam logic [1:0] WR_DIV2 = 2'h2;
  localparam logic [1:0] WR_RSVD = 2'h3;
  // ********************************
  // Controller register map
  // ********************************
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CMD = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_MRS = 2'h2;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : dtc_pkg

/* File: dtc_link_if.sv */
// Pins between the memory controller end and the memory device end.
// Assumes the controller drives every pin; the device only samples.
interface dtc_link_if;
  logic ck;                // Link clock made by the controller
  logic odt;               // Termination request pin
  logic wr;                // Write command
  logic bc4;               // Write is chopped to four beats
  logic mrs;               // Mode register load
  logic [1:0] mr_sel;      // Which mode register
  logic [15:0] mr_val;     // Value loaded
  modport dev (input ck, odt, wr, bc4, mrs, mr_sel, mr_val);
  modport ctl (output ck, odt, wr, bc4, mrs, mr_sel, mr_val);
endinterface : dtc_link_if

/* File: dtc_device.sv */
// Termination control of the memory device: strength and on/off of the I/O termination.
// Assumes the link pins come from another domain and change only while the link clock is low.
module dtc_device (
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  dtc_link_if.dev LINK,
  output logic RTT_ON_OUT,
  output logic [2:0] RTT_CODE_OUT,
  output logic RTT_UNDEF_OUT,
  output logic DYN_EN_OUT
);
  localparam int PW = 22;
  localparam int HW = 32;

  // ********************************
  // Pin synchronisers
  // ********************************
  logic ck_s1_r, ck_s2_r, ck_s3_r, ck_lvl_r;
  logic [PW-1:0] pin_s1_r, pin_s2_r, pin_s3_r;
  wire [PW-1:0] pins = {LINK.odt, LINK.wr, LINK.bc4, LINK.mrs, LINK.mr_sel, LINK.mr_val};

  // Three stages; the first is read only by the second
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      // Link clock idles high in reset, so the stages start high to avoid a false rise
      ck_s1_r <= 1'b1;
      ck_s2_r <= 1'b1;
      ck_s3_r <= 1'b1;
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end else begin
      ck_s1_r <= LINK.ck;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
      pin_s1_r <= pins;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // A clock change counts once the second and third stages agree
  wire ck_agree = (ck_s2_r == ck_s3_r);
  wire ck_rise = ck_agree && ck_s3_r && !ck_lvl_r;
  wire ck_lvl_nxt = ck_agree ? ck_s3_r : ck_lvl_r;
  wire odt_smp = pin_s3_r[21];
  wire wr_smp = pin_s3_r[20];
  wire bc4_smp = pin_s3_r[19];
  wire mrs_smp = pin_s3_r[18];
  wire [1:0] sel_smp = pin_s3_r[17:16];
  wire [15:0] val_smp = pin_s3_r[15:0];

  // ********************************
  // Mode registers and decode
  // ********************************
  logic [15:0] mr0_r, mr1_r, mr2_r;
  wire ld = ck_rise && mrs_smp;

  // Loads take effect from the next link edge
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      mr0_r <= dtc_pkg::MR_RST;
      mr1_r <= dtc_pkg::MR_RST;
      mr2_r <= dtc_pkg::MR_RST;
    end else begin
      if (ld && sel_smp == dtc_pkg::SEL_MR0) mr0_r <= val_smp;
      if (ld && sel_smp == dtc_pkg::SEL_MR1) mr1_r <= val_smp;
      if (ld && sel_smp == dtc_pkg::SEL_MR2) mr2_r <= val_smp;
    end
  end

  // Nominal code in bit order 9,6,2
  wire [2:0] nom_fld = {mr1_r[dtc_pkg::MR1_NOM_B2], mr1_r[dtc_pkg::MR1_NOM_B1],
                        mr1_r[dtc_pkg::MR1_NOM_B0]};
  wire nom_rsvd = (nom_fld[2:1] == 2'h3);
  wire [2:0] nom_code = nom_rsvd ? dtc_pkg::RTT_OFF : nom_fld;
  wire [1:0] wr_fld = mr2_r[dtc_pkg::MR2_WR_LO +: 2];
  // Write value maps onto the shared strength codes; 11 is treated as off
  wire [2:0] wr_code = (wr_fld == dtc_pkg::WR_DIV4) ? dtc_pkg::RTT_DIV4 :
                       (wr_fld == dtc_pkg::WR_DIV2) ? dtc_pkg::RTT_DIV2 :
                       dtc_pkg::RTT_OFF;
  wire dyn_en = mr2_r[dtc_pkg::MR2_WR_LO] | mr2_r[dtc_pkg::MR2_WR_LO + 1];

  // Latency: CWL from MR2, CL from MR0, AL of 0, CL-1 or CL-2
  wire [5:0] cwl = dtc_pkg::CWL_BASE + {3'h0, mr2_r[dtc_pkg::MR2_CWL_LO +: 3]};
  wire [5:0] cl = dtc_pkg::CL_BASE + {3'h0, mr0_r[dtc_pkg::MR0_CL_LO +: 3]};
  wire [1:0] al_fld = mr1_r[dtc_pkg::MR1_AL_LO +: 2];
  wire [5:0] al = (al_fld == 2'h1) ? cl - 6'h01 : (al_fld == 2'h2) ? cl - 6'h02 : 6'h00;
  wire [5:0] odtl = cwl + al - dtc_pkg::ODTL_SUB;
  wire [5:0] tail = bc4_smp ? dtc_pkg::TAIL_BC4 : dtc_pkg::TAIL_BL8;

  // ********************************
  // Pin history and write window
  // ********************************
  logic [HW-1:0] odt_hist_r;
  logic [5:0] on_cnt_r, off_cnt_r;
  logic wr_sel_r;
  // A write pin assertion counts only while the write value is enabled: chop and full-length alike
  wire wr_go = ck_rise && wr_smp && dyn_en;
  wire [5:0] on_cnt_nxt = wr_go ? odtl : (ck_rise && on_cnt_r != 6'h00) ?
                          on_cnt_r - 6'h01 : on_cnt_r;
  wire [5:0] off_cnt_nxt = wr_go ? odtl + tail : (ck_rise && off_cnt_r != 6'h00) ?
                           off_cnt_r - 6'h01 : off_cnt_r;
  // A later write's switch-on wins over an earlier write's switch-back
  wire wr_sel_nxt = !dyn_en ? 1'b0 :
                    (ck_rise && on_cnt_r == 6'h01) ? 1'b1 :
                    (ck_rise && off_cnt_r == 6'h01) ? 1'b0 :
                    wr_sel_r;

  // Link-domain state advances on a detected link rising edge; ck_lvl_r tracks every settled level and wr_sel_r clears once dyn_en drops
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      odt_hist_r <= '0;
      on_cnt_r <= 6'h00;
      off_cnt_r <= 6'h00;
      wr_sel_r <= 1'b0;
      ck_lvl_r <= 1'b1;
    end else begin
      if (ck_rise) odt_hist_r <= {odt_hist_r[HW-2:0], odt_smp};
      on_cnt_r <= on_cnt_nxt;
      off_cnt_r <= off_cnt_nxt;
      wr_sel_r <= wr_sel_nxt;
      ck_lvl_r <= ck_lvl_nxt;
    end
  end

  // Pin seen odtl edges ago: same latency for on and off
  wire [4:0] tap = odtl[4:0] - 5'h01;
  wire pin_late = odt_hist_r[tap];
  // Strength follows the write window, on/off still follows the pin
  wire [2:0] sel_code = wr_sel_nxt ? wr_code : nom_code;
  wire tgt_on = pin_late && (sel_code != dtc_pkg::RTT_OFF);

  // ********************************
  // Change skew
  // ********************************
  logic [7:0] per_cnt_r, half_r, adc_cnt_r;
  logic tgt_on_r, on_r, undef_r;
  logic [2:0] tgt_code_r, code_r;
  wire tgt_chg = (tgt_on != tgt_on_r) || (sel_code != tgt_code_r);
  wire adc_done = (adc_cnt_r == 8'h01);

  // Half the measured link period stands in for the 0.5 tCK skew;
  // the output is flagged undefined over that window
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      per_cnt_r <= 8'h00;
      half_r <= 8'h01;
      adc_cnt_r <= 8'h00;
      tgt_on_r <= 1'b0;
      tgt_code_r <= dtc_pkg::RTT_OFF;
      on_r <= 1'b0;
      code_r <= dtc_pkg::RTT_OFF;
      undef_r <= 1'b0;
    end else begin
      per_cnt_r <= ck_rise ? 8'h01 : per_cnt_r + 8'h01;
      if (ck_rise && per_cnt_r > 8'h01) half_r <= {1'b0, per_cnt_r[7:1]};
      if (ck_rise && tgt_chg) begin
        tgt_on_r <= tgt_on;
        tgt_code_r <= sel_code;
        adc_cnt_r <= half_r;
      end else if (adc_cnt_r != 8'h00) begin
        adc_cnt_r <= adc_cnt_r - 8'h01;
      end
      if (adc_done) begin
        on_r <= tgt_on_r;
        code_r <= tgt_code_r;
      end
      undef_r <= (ck_rise && tgt_chg) || (adc_cnt_r > 8'h01);
    end
  end

  // A strength is shown only while the termination is on
  assign RTT_ON_OUT = on_r;
  assign RTT_CODE_OUT = on_r ? code_r : dtc_pkg::RTT_OFF;
  assign RTT_UNDEF_OUT = undef_r;
  assign DYN_EN_OUT = dyn_en;

endmodule : dtc_device

/* File: dtc_ctrl.sv */
// Memory controller end: drives link clock, commands and the termination pin.
// Assumes software orders it over AXI4-Lite and one command per link clock.
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
module dtc_ctrl (
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic [3:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic [3:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input wire logic RREADY_IN,
  dtc_link_if.ctl LINK
);
  // ********************************
  // Bus slave
  // ********************************
  logic aw_ok_r, w_ok_r, bvalid_r, rvalid_r, bad_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [1:0] rresp_r;
  wire wr_fire = aw_ok_r && w_ok_r && !bvalid_r;
  wire wa_ctrl = (awaddr_r == dtc_pkg::OFS_CTRL);
  wire wa_cmd = (awaddr_r == dtc_pkg::OFS_CMD);
  wire wa_stat = (awaddr_r == dtc_pkg::OFS_STAT);
  wire wa_hit = wa_ctrl || wa_cmd || wa_stat;

  logic odt_req_r, pend_r, rej_r, pin_odt_r;
  logic [31:0] cmd_r;
  logic [3:0] hold_r;
  wire [31:0] stat = {28'h0, hold_r != 4'h0, rej_r, pin_odt_r, pend_r};
  wire [31:0] rd_mux = (ARADDR_IN == dtc_pkg::OFS_CTRL) ? {31'h0, odt_req_r} :
                       (ARADDR_IN == dtc_pkg::OFS_CMD) ? cmd_r :
                       (ARADDR_IN == dtc_pkg::OFS_STAT) ? stat : 32'h0;
  wire ra_hit = (ARADDR_IN == dtc_pkg::OFS_CTRL) || (ARADDR_IN == dtc_pkg::OFS_CMD) ||
                (ARADDR_IN == dtc_pkg::OFS_STAT);

  // Address and data taken in either order; response after both
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      bvalid_r <= 1'b0;
      bad_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= dtc_pkg::RESP_OK;
    end else begin
      if (AWVALID_IN && AWREADY_OUT) aw_ok_r <= 1'b1;
      if (AWVALID_IN && AWREADY_OUT) awaddr_r <= AWADDR_IN;
      if (WVALID_IN && WREADY_OUT) w_ok_r <= 1'b1;
      if (WVALID_IN && WREADY_OUT) wdata_r <= WDATA_IN;
      if (wr_fire) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        bvalid_r <= 1'b1;
        bad_r <= !wa_hit;
      end else if (BREADY_IN) begin
        bvalid_r <= 1'b0;
      end
      if (ARVALID_IN && ARREADY_OUT) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= ra_hit ? dtc_pkg::RESP_OK : dtc_pkg::RESP_ERR;
      end else if (RREADY_IN) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign AWREADY_OUT = !aw_ok_r && !bvalid_r;
  assign WREADY_OUT = !w_ok_r && !bvalid_r;
  assign BVALID_OUT = bvalid_r;
  assign BRESP_OUT = bad_r ? dtc_pkg::RESP_ERR : dtc_pkg::RESP_OK;
  assign ARREADY_OUT = !rvalid_r;
  assign RVALID_OUT = rvalid_r;
  assign RDATA_OUT = rdata_r;
  assign RRESP_OUT = rresp_r;

  // ********************************
  // Order checks
  // ********************************
  logic [15:0] mr1_r, mr2_r;
  wire [15:0] val = wdata_r[31:16];
  wire [1:0] sel = wdata_r[5:4];
  wire dll_off = mr1_r[dtc_pkg::MR1_DLL_OFF];
  // Write value forced off while the DLL is off
  wire [15:0] val_fix = (sel == dtc_pkg::SEL_MR2 && dll_off) ? (val & 16'hF9FF) : val;
  wire [15:0] n1 = (sel == dtc_pkg::SEL_MR1) ? val : mr1_r;
  wire [15:0] n2 = (sel == dtc_pkg::SEL_MR2) ? val_fix : mr2_r;
  wire [2:0] nom = {n1[dtc_pkg::MR1_NOM_B2], n1[dtc_pkg::MR1_NOM_B1], n1[dtc_pkg::MR1_NOM_B0]};
  wire [1:0] wrv = n2[dtc_pkg::MR2_WR_LO +: 2];
  wire bad_code = (nom[2:1] == 2'h3) || (wrv == dtc_pkg::WR_RSVD);
  wire bad_nom = (wrv == 2'h0) && (nom == dtc_pkg::RTT_DIV12 || nom == dtc_pkg::RTT_DIV8);
  wire is_mrs = (wdata_r[1:0] == dtc_pkg::OP_MRS);
  wire accept = wr_fire && wa_cmd && !pend_r && !(is_mrs && (bad_code || bad_nom));
  wire refuse = wr_fire && wa_cmd && !accept;

  // ********************************
  // Link clock and pins
  // ********************************
  logic [3:0] div_r;
  wire tick = (div_r == 4'(dtc_pkg::CK_HALF - 1));   // Link clock about to fall
  wire issue = tick && pend_r;
  // Only writes and mode loads are issued, so the pin never overlaps a read
  wire is_wr = (cmd_r[1:0] == dtc_pkg::OP_WRITE);
  wire odt_new = odt_req_r || (hold_r != 4'h0);
  wire [3:0] len = cmd_r[2] ? dtc_pkg::HOLD_BASE : dtc_pkg::HOLD_BL8;
  wire [3:0] dec = (hold_r != 4'h0) ? hold_r - 4'h1 : 4'h0;
  wire [3:0] wr_keep = (len - 4'h1 > dec) ? len - 4'h1 : dec;
  wire [3:0] hold_nxt = (issue && is_wr && odt_new) ? wr_keep :
                        (odt_new && !pin_odt_r) ? dtc_pkg::HOLD_BASE - 4'h1 : dec;

  // Pins change as the link clock falls so the device sees them settled
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      div_r <= 4'h0;
      pin_odt_r <= 1'b0;
      hold_r <= 4'h0;
      LINK.wr <= 1'b0;
      LINK.bc4 <= 1'b0;
      LINK.mrs <= 1'b0;
      LINK.mr_sel <= 2'h0;
      LINK.mr_val <= 16'h0000;
    end else begin
      div_r <= (div_r == 4'(dtc_pkg::CK_DIV - 1)) ? 4'h0 : div_r + 4'h1;
      if (tick) begin
        pin_odt_r <= odt_new;
        hold_r <= hold_nxt;
        LINK.wr <= issue && is_wr;
        LINK.bc4 <= issue && cmd_r[2];
        LINK.mrs <= issue && (cmd_r[1:0] == dtc_pkg::OP_MRS);
        LINK.mr_sel <= cmd_r[5:4];
        LINK.mr_val <= cmd_r[31:16];
      end
    end
  end

  assign LINK.ck = (div_r < 4'(dtc_pkg::CK_HALF));
  assign LINK.odt = pin_odt_r;

  // Control, command and sticky refusal; a refusal wins over its clear
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      odt_req_r <= 1'b0;
      pend_r <= 1'b0;
      rej_r <= 1'b0;
      cmd_r <= 32'h0;
      mr1_r <= dtc_pkg::MR_RST;
      mr2_r <= dtc_pkg::MR_RST;
    end else begin
      if (wr_fire && wa_ctrl && WSTRB_IN[0]) odt_req_r <= wdata_r[0];
      if (refuse) rej_r <= 1'b1;
      else if (wr_fire && wa_stat && wdata_r[2]) rej_r <= 1'b0;
      if (accept) begin
        pend_r <= 1'b1;
        cmd_r <= {val_fix, wdata_r[15:0]};
        if (is_mrs && sel == dtc_pkg::SEL_MR1) mr1_r <= val;
        if (is_mrs && sel == dtc_pkg::SEL_MR2) mr2_r <= val_fix;
      end else if (issue) begin
        pend_r <= 1'b0;
      end
    end
  end

endmodule : dtc_ctrl

/* File: dtc_link_chk.sv */
// Checker for the link pins and the device termination outputs.
// Assumes one system clock domain; instantiated beside the link interface.
module dtc_link_chk (
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic ck,
  input wire logic odt,
  input wire logic wr,
  input wire logic bc4,
  input wire logic mrs,
  input wire logic [1:0] mr_sel,
  input wire logic [15:0] mr_val,
  input wire logic RTT_ON_OUT,
  input wire logic [2:0] RTT_CODE_OUT,
  input wire logic RTT_UNDEF_OUT
);
  // ********************************
  // Helper counters
  // ********************************
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  int hi_cnt_r;
  int wr_cnt_r;
  logic wr_d_r;
  logic wr_seen_r;
  logic wr_bl8_r;
  // High run of the pin and age of the last write taken with the pin high
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      hi_cnt_r <= 0;
      wr_cnt_r <= 0;
      wr_d_r <= 1'b0;
      wr_seen_r <= 1'b0;
      wr_bl8_r <= 1'b0;
    end else begin
      hi_cnt_r <= odt ? hi_cnt_r + 1 : 0;
      wr_d_r <= wr;
      wr_cnt_r <= (wr && !wr_d_r) ? 1 : wr_cnt_r + 1;
      wr_seen_r <= (wr && !wr_d_r && odt) ? 1'b1 : (odt ? wr_seen_r : 1'b0);
      wr_bl8_r <= (wr && !wr_d_r) ? !bc4 : wr_bl8_r;
    end
  end
  sequence s_ck_hi;
    ck [*4];
  endsequence
  sequence s_ck_lo;
    !ck [*4];
  endsequence
  // ********************************
  // Assertions
  // ********************************
  // Link clock halves are four system cycles each
  a_ck_high_time: assert property ($rose(ck) |-> s_ck_hi ##1 !ck)
    else $error("link clock high time wrong");
  a_ck_low_time: assert property ($fell(ck) |-> s_ck_lo ##1 ck)
    else $error("link clock low time wrong");
  // Pins move only as the link clock falls, so the device samples settled values
  a_pins_on_fall: assert property (!$stable({odt, wr, bc4, mrs, mr_sel, mr_val}) |-> $fell(ck))
    else $error("link pin changed away from clock fall");
  a_wr_one_period: assert property ($rose(wr) |-> wr [*8])
    else $error("write command shorter than a link period");
  a_mrs_one_period: assert property ($rose(mrs) |-> mrs [*8])
    else $error("mode load shorter than a link period");
  a_odt_hold_four: assert property ($fell(odt) |-> hi_cnt_r >= 32)
    else $error("pin dropped before four link clocks");
  a_odt_hold_write: assert property ($fell(odt) && wr_seen_r |-> wr_cnt_r >= (wr_bl8_r ? 48 : 32))
    else $error("pin dropped too soon after a write");
  a_skew_window: assert property ($rose(RTT_UNDEF_OUT) |-> RTT_UNDEF_OUT [*3] ##[1:3] !RTT_UNDEF_OUT)
    else $error("undefined window has wrong length");
  a_off_code_zero: assert property (!RTT_ON_OUT |-> RTT_CODE_OUT == 3'h0)
    else $error("strength code shown while off");
  a_no_rsvd_code: assert property (RTT_ON_OUT |-> RTT_CODE_OUT < 3'h6 && RTT_CODE_OUT != 3'h0)
    else $error("reserved strength code shown");
endmodule : dtc_link_chk

/* File: testbench.sv */
// Testbench: controller end and device end joined by the link, ordered over AXI4-Lite.
// Assumes the package, interface, both ends and the link checker are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // Signals and instances
  // ********************************
  logic clk, nrst, awv, wv, bre, arv, rre, awr, wrdy, bv, arr, rv, r_on, r_un, dyn, wr_d;
  logic [3:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] br, rr;
  logic [2:0] r_code;
  int miscompares, n_checks, cwl, al, nom, wsel, bc, lat, since, cyc, ndiff, wr_at, first_at;
  dtc_link_if link();
  dtc_device i_dtc_device (.SYS_CLK_IN(clk), .NRST_IN(nrst), .LINK(link), .RTT_ON_OUT(r_on),
    .RTT_CODE_OUT(r_code), .RTT_UNDEF_OUT(r_un), .DYN_EN_OUT(dyn));
  dtc_ctrl i_dtc_ctrl (.SYS_CLK_IN(clk), .NRST_IN(nrst), .AWADDR_IN(awa), .AWVALID_IN(awv),
    .AWREADY_OUT(awr), .WDATA_IN(wd), .WSTRB_IN(4'hF), .WVALID_IN(wv), .WREADY_OUT(wrdy),
    .BRESP_OUT(br), .BVALID_OUT(bv), .BREADY_IN(bre), .ARADDR_IN(ara), .ARVALID_IN(arv),
    .ARREADY_OUT(arr), .RDATA_OUT(rd), .RRESP_OUT(rr), .RVALID_OUT(rv), .RREADY_IN(rre),
    .LINK(link));
  dtc_link_chk i_dtc_link_chk (.SYS_CLK_IN(clk), .NRST_IN(nrst), .ck(link.ck), .odt(link.odt),
    .wr(link.wr), .bc4(link.bc4), .mrs(link.mrs), .mr_sel(link.mr_sel), .mr_val(link.mr_val),
    .RTT_ON_OUT(r_on), .RTT_CODE_OUT(r_code), .RTT_UNDEF_OUT(r_un));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Stamps: pin high run, write start, cycles away from the nominal strength
  always @(posedge clk) begin
    cyc <= cyc + 1;
    since <= link.odt ? since + 1 : 0;
    wr_d <= link.wr;
    if (link.wr && !wr_d) wr_at <= cyc;
    if (r_on === 1'b1 && r_un === 1'b0 && r_code !== nom[2:0]) begin
      if (ndiff == 0) first_at <= cyc;
      ndiff <= ndiff + 1;
    end
  end
  // ********************************
  // Tasks
  // ********************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic rng(input int v, input int lo, input int hi);
    n_checks++;
    if (v < lo || v > hi) begin
      miscompares++;
      $display("CHECK FAILED t=%0t count %0d not in %0d..%0d", $time, v, lo, hi);
    end
  endtask : rng
  // Bus write; bready and rready stay high, so only valids move
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad, wdn;
    ad = 0;
    wdn = 0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ad && wdn)) begin
      @(posedge clk);
      if (awr && !ad) awv <= 1'b0;
      if (wrdy && !wdn) wv <= 1'b0;
      ad = ad | awr;
      wdn = wdn | wrdy;
    end
    do @(posedge clk); while (!bv);
    chk(br, er);
  endtask : axw
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    d = rd;
    r = rr;
  endtask : axr
  task automatic cmd(input logic [1:0] op, input logic b, input logic [1:0] sel, input int v);
    logic [31:0] s;
    logic [1:0] r;
    axw(dtc_pkg::OFS_CMD, {v[15:0], 10'h000, sel, 1'b0, b, op}, dtc_pkg::RESP_OK);
    do axr(dtc_pkg::OFS_STAT, s, r); while (s[0] === 1'b1);
    repeat (16) @(posedge clk);
  endtask : cmd
  task automatic mr(input logic [1:0] sel, input int v, input bit bad);
    logic [31:0] s;
    logic [1:0] r;
    cmd(dtc_pkg::OP_MRS, 1'b0, sel, v);
    axr(dtc_pkg::OFS_STAT, s, r);
    chk(s[2], bad);
    if (s[2] === 1'b1) axw(dtc_pkg::OFS_STAT, 32'h4, dtc_pkg::RESP_OK);
  endtask : mr
  task automatic odt_on(input int odtl, input int code);
    axw(dtc_pkg::OFS_CTRL, 32'h1, dtc_pkg::RESP_OK);
    while (r_on !== 1'b1) @(posedge clk);
    lat = since;
    rng(lat, odtl * 8 + 4, odtl * 8 + 16);
    repeat (6) @(posedge clk);
    chk(r_code, code);
  endtask : odt_on
  task automatic odt_off();
    axw(dtc_pkg::OFS_CTRL, 32'h0, dtc_pkg::RESP_OK);
    while (r_on !== 1'b0) @(posedge clk);
    @(posedge clk);
    chk(r_code, 0);
  endtask : odt_off
  // Write with the pin high; counts cycles spent away from the nominal strength
  task automatic wr_test(input logic b, input bit on);
    int odtl, tl;
    odtl = cwl + al - 2;
    tl = b ? 4 : 6;
    ndiff = 0;
    cmd(dtc_pkg::OP_WRITE, b, 2'h0, 0);
    repeat (odtl * 8 + 80) @(posedge clk);
    rng(ndiff, on ? tl * 8 - 8 : 0, on ? tl * 8 + 2 : 0);
    if (on) rng(first_at - wr_at, odtl * 8 + 4, odtl * 8 + 16);
    chk(r_code, nom);
  endtask : wr_test
  task automatic complete_run();
    $display("Checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  // Watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    #400000;
    miscompares++;
    complete_run();
  end
  // ********************************
  // Main sequence
  // ********************************
  initial begin
    logic [31:0] s;
    logic [1:0] r;
    {nrst, awv, wv, arv, wr_d, awa, ara, wd} = '0;
    {bre, rre} = 2'b11;
    {miscompares, n_checks, nom, al, cyc, since, ndiff, wr_at, first_at} = '0;
    cwl = 5;
    void'($urandom(32'hE9F7));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    axr(dtc_pkg::OFS_STAT, s, r);
    chk(s, 0);
    chk({r_on, r_code, r_un, dyn}, 0);
    axr(4'hC, s, r);
    chk(r, dtc_pkg::RESP_ERR);
    axw(4'hC, 32'h0, dtc_pkg::RESP_ERR);
    // Every write-value code; the reserved one is refused and changes nothing
    for (int w = 0; w < 4; w++) begin
      mr(dtc_pkg::SEL_MR2, w << 9, w == 3);
      chk(dyn, w != 0);
    end
    mr(dtc_pkg::SEL_MR1, 1, 0);
    mr(dtc_pkg::SEL_MR2, 32'h200, 0);
    chk(dyn, 0);
    mr(dtc_pkg::SEL_MR1, 0, 0);
    mr(dtc_pkg::SEL_MR2, 32'h200, 0);
    // Every nominal code but off (1 to 7) with AL zero; latency three link clocks
    for (int c = 1; c < 8; c++) begin
      mr(dtc_pkg::SEL_MR1, {c[2], 2'b00, c[1], 3'b000, c[0], 2'b00}, c > 5);
      if (c < 6) begin
        nom = c;
        odt_on(3, c);
        odt_off();
      end
    end
    mr(dtc_pkg::SEL_MR2, 0, 1);
    mr(dtc_pkg::SEL_MR1, 0, 0);
    mr(dtc_pkg::SEL_MR2, 0, 0);
    mr(dtc_pkg::SEL_MR1, 32'h200, 1);
    // Nominal /6 with AL of CL-1 and CWL 6: latency seven link clocks
    nom = 3;
    al = 3;
    cwl = 6;
    mr(dtc_pkg::SEL_MR1, 32'h4C, 0);
    for (int i = 0; i < 5; i++) begin
      wsel = (i == 4) ? 0 : $urandom_range(2, 1);
      bc = $urandom_range(1, 0);
      mr(dtc_pkg::SEL_MR2, 32'h8 | (wsel << 9), 0);
      chk(dyn, wsel != 0);
      if (i == 0) odt_on(7, 3);
      wr_test(bc[0], wsel != 0);
    end
    odt_off();
    complete_run();
  end
endmodule : testbench
